/* File: hdl/sdcfg_defs.svh */
`ifndef SDCFG_DEFS_SVH
`define SDCFG_DEFS_SVH

// Register byte offsets.
`define SDCFG_OFS_CONFIG   8'h08
`define SDCFG_OFS_TIMING0  8'h0c
`define SDCFG_OFS_TIMING1  8'h10
`define SDCFG_OFS_TIMING2  8'h14
`define SDCFG_OFS_LOWPOWER 8'h1c
`define SDCFG_OFS_MEMTYPE  8'h20
`define SDCFG_OFS_STATUS   8'h30
`define SDCFG_OFS_PROTECT  8'he4

// Reset values and implemented-bit masks.
`define SDCFG_RST_CONFIG   32'h0000_7024
`define SDCFG_MSK_CONFIG   32'h0005_73fc
`define SDCFG_RST_TIMING0  32'h2022_7225
`define SDCFG_MSK_TIMING0  32'hffff_ffff
`define SDCFG_RST_TIMING1  32'h03c8_0808
`define SDCFG_MSK_TIMING1  32'h0fff_ff1f
`define SDCFG_RST_TIMING2  32'h0000_2062
`define SDCFG_MSK_TIMING2  32'h0000_7fff
`define SDCFG_RST_LOWPOWER 32'h0001_0000
`define SDCFG_MSK_LOWPOWER 32'h0001_0000
`define SDCFG_RST_MEMTYPE  32'h0000_0000
`define SDCFG_MSK_MEMTYPE  32'h0000_0007
`define SDCFG_RST_PROTECT  32'h0000_0000
`define SDCFG_MSK_PROTECT  32'h0000_0001

// Configuration fields.
`define CFG_ROW_MSB   3
`define CFG_ROW_LSB   2
`define CFG_CAS_MSB   6
`define CFG_CAS_LSB   4
`define CFG_DLLRST    7
`define CFG_DRVIMP    8
`define CFG_DLLOFF    9
`define CFG_OCD_MSB   14
`define CFG_OCD_LSB   12
`define CFG_MASKSH    16
`define CFG_STOPBLK   18

// Timing 0 fields.
`define T0_RAS_MSB  3
`define T0_RAS_LSB  0
`define T0_RCD_MSB  7
`define T0_RCD_LSB  4
`define T0_WR_MSB   11
`define T0_WR_LSB   8
`define T0_RC_MSB   15
`define T0_RC_LSB   12
`define T0_RP_MSB   19
`define T0_RP_LSB   16
`define T0_RRD_MSB  23
`define T0_RRD_LSB  20
`define T0_WTR_MSB  26
`define T0_WTR_LSB  24
`define T0_SHORTWR  27
`define T0_MRD_MSB  31
`define T0_MRD_LSB  28

// Timing 1 fields.
`define T1_RFC_MSB  4
`define T1_RFC_LSB  0
`define T1_XSNR_MSB 15
`define T1_XSNR_LSB 8
`define T1_XSRD_MSB 23
`define T1_XSRD_LSB 16
`define T1_XP_MSB   27
`define T1_XP_LSB   24

// Timing 2 fields.
`define T2_XARD_MSB  3
`define T2_XARD_LSB  0
`define T2_XARDS_MSB 7
`define T2_XARDS_LSB 4
`define T2_RPA_MSB   11
`define T2_RPA_LSB   8
`define T2_RTP_MSB   14
`define T2_RTP_LSB   12

// Other control bits.
`define LP_APD_SLOW  16
`define PROT_ON      0

// Row bits and CAS codes.
`define ROW_BITS_BASE 4'hb
`define CAS_CODE_2    3'h2
`define CAS_CODE_3    3'h3

// Memory type codes.
`define MT_SDR    3'h0
`define MT_LPSDR  3'h1
`define MT_LPDDR  3'h3
`define MT_DDR2   3'h6

// Global counter indices.
`define G_RC   0
`define G_RP   1
`define G_RRD  2
`define G_WTR  3
`define G_MRD  4
`define G_RFC  5
`define G_XSNR 6
`define G_XSRD 7
`define G_XP   8
`define G_XARD 9
`define G_NUM  10

`endif

/* File: hdl/sdcfg_pkg.sv */
`default_nettype none

package sdcfg_pkg;

   typedef enum logic [3:0] {
      SDCFG_CMD_NOP,
      SDCFG_CMD_ACT,
      SDCFG_CMD_READ,
      SDCFG_CMD_WRITE,
      SDCFG_CMD_PRE,
      SDCFG_CMD_PRE_ALL,
      SDCFG_CMD_REFRESH,
      SDCFG_CMD_LOAD_MODE,
      SDCFG_CMD_BURST_STOP
   } sdcfg_cmd_e;

   typedef struct packed {
      logic [3:0] row_bits;
      logic [2:0] cas_code;
      logic       cas_legal;
      logic       dll_reset;
      logic       delay_loop_off;
      logic       driver_impedance_sel;
      logic [2:0] off_chip_driver;
      logic       mask_lines_shared;
      logic       cross_bank_stop_block;
   } sdcfg_cfg_s;

endpackage

`default_nettype wire

/* File: hdl/sdcfg_timing.sv */
// Contract
// - Row code selects 11 to 14 row bits.
// - CAS latency code resets to two cycles.
// - DLL reset and DLL disable bits exported.
// - Driver impedance bit selects normal or weak.
// - Mask sharing bit marks mask lines shared.
// - Optional ban on cross-bank burst stop.
// - Protected registers ignore writes while protected.
// - Activate to precharge spacing per bank.
// - Activate to read or write spacing.
// - Write recovery before precharging that bank.
// - Activate to refresh spacing.
// - Precharge or precharge-all blocks next command.
// - Activate to other bank spacing.
// - Write to read delay one to seven.
// - Mode load to activate or refresh spacing.
// - Refresh to activate or refresh spacing.
// - Self refresh exit waits before commands.
// - Power-down exit waits before any command.
// - Active power-down exit waits before read.
// - Read to precharge spacing per bank.
// - Exit speed bit picks fast or slow.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "sdcfg_defs.svh"
`default_nettype none

module sdcfg_timing
   import sdcfg_pkg::*;
#(
   parameter int NBANK = 4
) (
   // Clock, reset and enable
   input  wire logic             CLOCK_I,
   input  wire logic             RESETN_I,
   input  wire logic             CE_I,
   // Register port
   input  wire logic [7:0]       ADDR_I,
   input  wire logic [31:0]      WR_DATA_I,
   input  wire logic             WR_STB_I,
   input  wire logic             RD_STB_I,
   output logic      [31:0]      RD_DATA_O,
   // Command request
   input  wire logic             CMD_VALID_I,
   input  wire sdcfg_cmd_e       CMD_I,
   input  wire logic [$clog2(NBANK)-1:0] CMD_BANK_I,
   output logic                  CMD_READY_O,
   // Low-power exit events
   input  wire logic             EXIT_SELFREF_I,
   input  wire logic             EXIT_PWRDN_I,
   input  wire logic             PWRDN_ACTIVE_I,
   // Configuration out
   output sdcfg_cfg_s            CFG_O
);

   localparam int BW = $clog2(NBANK);

   logic [31:0] reg_config;
   logic [31:0] reg_timing0;
   logic [31:0] reg_timing1;
   logic [31:0] reg_timing2;
   logic [31:0] reg_lowpower;
   logic [31:0] reg_memtype;
   logic [31:0] reg_protect;
   logic [31:0] rd_data;
   sdcfg_cfg_s  cfg;

   logic [7:0]  gcnt [`G_NUM];
   logic [3:0]  ras_cnt [NBANK];
   logic [3:0]  rcd_cnt [NBANK];
   logic [3:0]  wr_cnt [NBANK];
   logic [3:0]  rtp_cnt [NBANK];
   logic [BW-1:0] last_act_bank;
   logic        act_seen;

   logic [`G_NUM-1:0] next_gset;
   logic [7:0]  next_gval [`G_NUM];
   logic        issue;
   logic        allowed;

   function automatic logic [7:0] load_of(input logic [7:0] n);
      load_of = (n == 8'h00) ? 8'h00 : n - 8'h01;
   endfunction

   function automatic logic [3:0] load4(input logic [3:0] n);
      load4 = (n == 4'h0) ? 4'h0 : n - 4'h1;
   endfunction

   // Timing fields.
   wire logic [3:0] act_to_pre_cycles       = reg_timing0[`T0_RAS_MSB:`T0_RAS_LSB];
   wire logic [3:0] row_to_col_cycles       = reg_timing0[`T0_RCD_MSB:`T0_RCD_LSB];
   wire logic [3:0] write_recovery_cycles   = reg_timing0[`T0_WR_MSB:`T0_WR_LSB];
   wire logic [3:0] act_to_refresh_cycles   = reg_timing0[`T0_RC_MSB:`T0_RC_LSB];
   wire logic [3:0] pre_to_cmd_cycles       = reg_timing0[`T0_RP_MSB:`T0_RP_LSB];
   wire logic [3:0] bank_to_bank_act_cycles = reg_timing0[`T0_RRD_MSB:`T0_RRD_LSB];
   wire logic [2:0] write_read_field        = reg_timing0[`T0_WTR_MSB:`T0_WTR_LSB];
   wire logic       short_write_read        = reg_timing0[`T0_SHORTWR];
   wire logic [3:0] modeload_to_cmd_cycles  = reg_timing0[`T0_MRD_MSB:`T0_MRD_LSB];
   wire logic [4:0] refresh_cycle_count     = reg_timing1[`T1_RFC_MSB:`T1_RFC_LSB];
   wire logic [7:0] selfref_exit_nonread    = reg_timing1[`T1_XSNR_MSB:`T1_XSNR_LSB];
   wire logic [7:0] selfref_exit_read       = reg_timing1[`T1_XSRD_MSB:`T1_XSRD_LSB];
   wire logic [3:0] powerdown_exit_cycles   = reg_timing1[`T1_XP_MSB:`T1_XP_LSB];
   wire logic [3:0] fast_exit_read_cycles   = reg_timing2[`T2_XARD_MSB:`T2_XARD_LSB];
   wire logic [3:0] slow_exit_read_cycles   = reg_timing2[`T2_XARDS_MSB:`T2_XARDS_LSB];
   wire logic [3:0] pre_all_cycles          = reg_timing2[`T2_RPA_MSB:`T2_RPA_LSB];
   wire logic [2:0] read_to_pre_cycles      = reg_timing2[`T2_RTP_MSB:`T2_RTP_LSB];
   wire logic       active_pd_exit_speed    = reg_lowpower[`LP_APD_SLOW];
   wire logic       write_protect_on        = reg_protect[`PROT_ON];

   wire logic [2:0] mem_type = reg_memtype[2:0];
   wire logic is_ddr2  = (mem_type == `MT_DDR2);
   wire logic is_lpddr = (mem_type == `MT_LPDDR);
   wire logic is_sdr_class = (mem_type == `MT_SDR) || (mem_type == `MT_LPSDR) || is_lpddr;

   // Protected registers: config and the three timing registers.
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         reg_config  <= `SDCFG_RST_CONFIG;
         reg_timing0 <= `SDCFG_RST_TIMING0;
         reg_timing1 <= `SDCFG_RST_TIMING1;
         reg_timing2 <= `SDCFG_RST_TIMING2;
      end else if (CE_I && WR_STB_I && !write_protect_on) begin
         case (ADDR_I)
            `SDCFG_OFS_CONFIG:  reg_config  <= WR_DATA_I & `SDCFG_MSK_CONFIG;
            `SDCFG_OFS_TIMING0: reg_timing0 <= WR_DATA_I & `SDCFG_MSK_TIMING0;
            `SDCFG_OFS_TIMING1: reg_timing1 <= WR_DATA_I & `SDCFG_MSK_TIMING1;
            `SDCFG_OFS_TIMING2: reg_timing2 <= WR_DATA_I & `SDCFG_MSK_TIMING2;
            default: ;
         endcase
      end
   end

   // Unprotected control registers.
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         reg_lowpower <= `SDCFG_RST_LOWPOWER;
         reg_memtype  <= `SDCFG_RST_MEMTYPE;
         reg_protect  <= `SDCFG_RST_PROTECT;
      end else if (CE_I && WR_STB_I) begin
         case (ADDR_I)
            `SDCFG_OFS_LOWPOWER: reg_lowpower <= WR_DATA_I & `SDCFG_MSK_LOWPOWER;
            `SDCFG_OFS_MEMTYPE:  reg_memtype  <= WR_DATA_I & `SDCFG_MSK_MEMTYPE;
            `SDCFG_OFS_PROTECT:  reg_protect  <= WR_DATA_I & `SDCFG_MSK_PROTECT;
            default: ;
         endcase
      end
   end

   // Busy view of every shared counter and of the bank counters of banks 0 to 3 only, for software and debug.
   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      for (int g = 0; g < `G_NUM; g++) begin
         status_word[g] = (gcnt[g] != 8'h00);
      end
      for (int b = 0; b < NBANK && b < 4; b++) begin
         status_word[16 + b]  = (ras_cnt[b] != 4'h0);
         status_word[20 + b]  = (rcd_cnt[b] != 4'h0);
         status_word[24 + b]  = (wr_cnt[b] != 4'h0);
         status_word[28 + b]  = (rtp_cnt[b] != 4'h0);
      end
   end

   // Read data stand only in the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         rd_data <= 32'h0000_0000;
      end else if (CE_I) begin
         rd_data <= 32'h0000_0000;
         if (RD_STB_I) begin
            case (ADDR_I)
               `SDCFG_OFS_CONFIG:   rd_data <= reg_config;
               `SDCFG_OFS_TIMING0:  rd_data <= reg_timing0;
               `SDCFG_OFS_TIMING1:  rd_data <= reg_timing1;
               `SDCFG_OFS_TIMING2:  rd_data <= reg_timing2;
               `SDCFG_OFS_LOWPOWER: rd_data <= reg_lowpower;
               `SDCFG_OFS_MEMTYPE:  rd_data <= reg_memtype;
               `SDCFG_OFS_PROTECT:  rd_data <= reg_protect;
               `SDCFG_OFS_STATUS:   rd_data <= status_word;
               default:             rd_data <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign RD_DATA_O = rd_data;

   // Geometry and power-up options, registered so the outputs come from flops.
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         cfg <= '0;
      end else if (CE_I) begin
         cfg.row_bits <= `ROW_BITS_BASE + {2'b00, reg_config[`CFG_ROW_MSB:`CFG_ROW_LSB]};
         cfg.cas_code <= reg_config[`CFG_CAS_MSB:`CFG_CAS_LSB];
         // Reserved CAS codes are flagged, not corrected; the code is software's to get right.
         cfg.cas_legal <= (reg_config[`CFG_CAS_MSB:`CFG_CAS_LSB] == `CAS_CODE_3) ||
                          (!is_ddr2 && reg_config[`CFG_CAS_MSB:`CFG_CAS_LSB] == `CAS_CODE_2);
         cfg.dll_reset <= reg_config[`CFG_DLLRST];
         cfg.delay_loop_off <= reg_config[`CFG_DLLOFF];
         cfg.driver_impedance_sel <= reg_config[`CFG_DRVIMP];
         cfg.off_chip_driver <= reg_config[`CFG_OCD_MSB:`CFG_OCD_LSB];
         cfg.mask_lines_shared <= reg_config[`CFG_MASKSH];
         cfg.cross_bank_stop_block <= reg_config[`CFG_STOPBLK];
      end
   end
   assign CFG_O = cfg;

   // Write to read delay in cycles.
   logic [2:0] wtr_cycles;
   always_comb begin
      if (is_lpddr && short_write_read && write_read_field == 3'h0 &&
          reg_config[`CFG_CAS_MSB:`CFG_CAS_LSB] == `CAS_CODE_2) begin
         wtr_cycles = 3'h0;
      end else if (is_lpddr) begin
         wtr_cycles = {2'b00, write_read_field[0]} + 3'h1;
      end else begin
         wtr_cycles = (write_read_field == 3'h0) ? 3'h1 : write_read_field;
      end
   end

   wire logic xsnr_busy = (gcnt[`G_XSNR] != 8'h00);
   wire logic all_busy  = (gcnt[`G_RP] != 8'h00) || (gcnt[`G_XP] != 8'h00);

   // Whether the requested command may go now.
   always_comb begin
      allowed = 1'b0;
      case (CMD_I)
         SDCFG_CMD_NOP: allowed = 1'b1;
         SDCFG_CMD_ACT: allowed = !xsnr_busy && (gcnt[`G_MRD] == 8'h00) &&
                                  (gcnt[`G_RFC] == 8'h00) &&
                                  ((gcnt[`G_RRD] == 8'h00) || CMD_BANK_I == last_act_bank);
         SDCFG_CMD_READ: allowed = (rcd_cnt[CMD_BANK_I] == 4'h0) &&
                                   (gcnt[`G_WTR] == 8'h00) &&
                                   (gcnt[`G_XSRD] == 8'h00) &&
                                   (gcnt[`G_XARD] == 8'h00);
         SDCFG_CMD_WRITE: allowed = !xsnr_busy && (rcd_cnt[CMD_BANK_I] == 4'h0);
         SDCFG_CMD_PRE: allowed = !xsnr_busy && (ras_cnt[CMD_BANK_I] == 4'h0) &&
                                  (wr_cnt[CMD_BANK_I] == 4'h0) &&
                                  (rtp_cnt[CMD_BANK_I] == 4'h0);
         SDCFG_CMD_PRE_ALL: begin
            allowed = !xsnr_busy;
            for (int b = 0; b < NBANK; b++) begin
               if (ras_cnt[b] != 4'h0 || wr_cnt[b] != 4'h0 || rtp_cnt[b] != 4'h0) begin
                  allowed = 1'b0;
               end
            end
         end
         SDCFG_CMD_REFRESH: allowed = !xsnr_busy && (gcnt[`G_RC] == 8'h00) &&
                                      (gcnt[`G_MRD] == 8'h00) &&
                                      (gcnt[`G_RFC] == 8'h00);
         SDCFG_CMD_LOAD_MODE: allowed = !xsnr_busy;
         SDCFG_CMD_BURST_STOP: allowed = !(cfg.cross_bank_stop_block && is_sdr_class &&
                                           act_seen && CMD_BANK_I != last_act_bank);
         default: allowed = 1'b0;
      endcase
      if (all_busy) begin
         allowed = 1'b0;
      end
   end

   assign CMD_READY_O = CMD_VALID_I && allowed;
   assign issue = CE_I && CMD_READY_O;

   // Loads for the shared counters; a count N lets the next command go N cycles later.
   always_comb begin
      next_gset = '0;
      for (int g = 0; g < `G_NUM; g++) begin
         next_gval[g] = 8'h00;
      end
      if (issue) begin
         case (CMD_I)
            SDCFG_CMD_ACT: begin
               next_gset[`G_RC]  = 1'b1;
               next_gval[`G_RC]  = load_of({4'h0, act_to_refresh_cycles});
               next_gset[`G_RRD] = 1'b1;
               next_gval[`G_RRD] = load_of({4'h0, bank_to_bank_act_cycles});
            end
            SDCFG_CMD_WRITE: begin
               next_gset[`G_WTR] = 1'b1;
               next_gval[`G_WTR] = load_of({5'h00, wtr_cycles});
            end
            SDCFG_CMD_PRE: begin
               next_gset[`G_RP] = 1'b1;
               next_gval[`G_RP] = load_of({4'h0, pre_to_cmd_cycles});
            end
            SDCFG_CMD_PRE_ALL: begin
               next_gset[`G_RP] = 1'b1;
               next_gval[`G_RP] = load_of({4'h0, is_ddr2 ? pre_all_cycles : pre_to_cmd_cycles});
            end
            SDCFG_CMD_REFRESH: begin
               next_gset[`G_RFC] = 1'b1;
               next_gval[`G_RFC] = load_of({3'h0, refresh_cycle_count});
            end
            SDCFG_CMD_LOAD_MODE: begin
               next_gset[`G_MRD] = 1'b1;
               next_gval[`G_MRD] = load_of({4'h0, modeload_to_cmd_cycles});
            end
            default: ;
         endcase
      end
      if (CE_I && EXIT_SELFREF_I) begin
         next_gset[`G_XSNR] = 1'b1;
         next_gval[`G_XSNR] = load_of(selfref_exit_nonread);
         next_gset[`G_XSRD] = 1'b1;
         next_gval[`G_XSRD] = (is_ddr2 || is_lpddr) ? load_of(selfref_exit_read) : 8'h00;
      end
      if (CE_I && EXIT_PWRDN_I) begin
         next_gset[`G_XP] = 1'b1;
         next_gval[`G_XP] = (is_ddr2 || is_lpddr) ?
                            load_of({4'h0, powerdown_exit_cycles}) : 8'h00;
         next_gset[`G_XARD] = 1'b1;
         next_gval[`G_XARD] = (is_ddr2 && PWRDN_ACTIVE_I) ?
                              load_of({4'h0, active_pd_exit_speed ? slow_exit_read_cycles
                                                                  : fast_exit_read_cycles})
                              : 8'h00;
      end
   end

   // Shared down-counters: a load takes priority over the count in the same cycle.
   generate
      for (genvar g = 0; g < `G_NUM; g++) begin : g_global
         always_ff @(posedge CLOCK_I) begin
            if (!RESETN_I) begin
               gcnt[g] <= 8'h00;
            end else if (CE_I) begin
               if (next_gset[g]) begin
                  gcnt[g] <= next_gval[g];
               end else if (gcnt[g] != 8'h00) begin
                  gcnt[g] <= gcnt[g] - 8'h01;
               end
            end
         end
      end
   endgenerate

   // Per-bank down-counters.
   generate
      for (genvar b = 0; b < NBANK; b++) begin : g_bank
         wire logic hit = issue && (CMD_BANK_I == BW'(b));
         always_ff @(posedge CLOCK_I) begin
            if (!RESETN_I) begin
               ras_cnt[b] <= 4'h0;
               rcd_cnt[b] <= 4'h0;
               wr_cnt[b]  <= 4'h0;
               rtp_cnt[b] <= 4'h0;
            end else if (CE_I) begin
               if (hit && CMD_I == SDCFG_CMD_ACT) begin
                  ras_cnt[b] <= load4(act_to_pre_cycles);
                  rcd_cnt[b] <= load4(row_to_col_cycles);
               end else begin
                  ras_cnt[b] <= (ras_cnt[b] != 4'h0) ? ras_cnt[b] - 4'h1 : 4'h0;
                  rcd_cnt[b] <= (rcd_cnt[b] != 4'h0) ? rcd_cnt[b] - 4'h1 : 4'h0;
               end
               if (hit && CMD_I == SDCFG_CMD_WRITE) begin
                  // A zero field still costs one cycle of recovery.
                  wr_cnt[b] <= load4((write_recovery_cycles == 4'h0) ? 4'h1
                                                                     : write_recovery_cycles);
               end else begin
                  wr_cnt[b] <= (wr_cnt[b] != 4'h0) ? wr_cnt[b] - 4'h1 : 4'h0;
               end
               if (hit && CMD_I == SDCFG_CMD_READ) begin
                  rtp_cnt[b] <= load4({1'b0, read_to_pre_cycles});
               end else begin
                  rtp_cnt[b] <= (rtp_cnt[b] != 4'h0) ? rtp_cnt[b] - 4'h1 : 4'h0;
               end
            end
         end
      end
   endgenerate

   // Last activated bank, for the bank-to-bank and burst-stop checks.
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         last_act_bank <= '0;
         act_seen      <= 1'b0;
      end else if (issue && CMD_I == SDCFG_CMD_ACT) begin
         last_act_bank <= CMD_BANK_I;
         act_seen      <= 1'b1;
      end
   end

endmodule // sdcfg_timing

`default_nettype wire

/* File: testbench/sdcfg_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sdcfg_mem_model (
   // Clock and reset
   input  wire logic        CLOCK_I,
   input  wire logic        RESETN_I,
   // Wake requests and issued commands
   input  wire logic        sr_req_i,
   input  wire logic        pd_req_i,
   input  wire logic        issued_i,
   // Exit events and command tally
   output logic             exit_sr_o,
   output logic             exit_pd_o,
   output logic             pd_act_o,
   output logic [15:0]      cmd_count_o
);
   // Clock enable rises once per exit, so each event is a single-cycle pulse.
   always_ff @(posedge CLOCK_I) begin
      exit_sr_o <= RESETN_I && sr_req_i;
      exit_pd_o <= RESETN_I && pd_req_i;
      pd_act_o  <= RESETN_I && pd_req_i;
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I)
         cmd_count_o <= 16'h0000;
      else if (issued_i)
         cmd_count_o <= cmd_count_o + 16'h0001;
   end
endmodule // sdcfg_mem_model

`default_nettype wire

/* File: testbench/sdcfg_timing_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module sdcfg_timing_monitor
   import sdcfg_pkg::*;
#(
   parameter int NBANK = 4
) (
   // Clock and reset
   input wire logic                     CLOCK_I,
   input wire logic                     RESETN_I,
   input wire logic                     CE_I,
   // Register port
   input wire logic [7:0]               ADDR_I,
   input wire logic                     WR_STB_I,
   input wire logic                     RD_STB_I,
   input wire logic [31:0]              RD_DATA_O,
   // Commands and configuration
   input wire logic                     CMD_VALID_I,
   input wire sdcfg_cmd_e               CMD_I,
   input wire logic [$clog2(NBANK)-1:0] CMD_BANK_I,
   input wire logic                     CMD_READY_O,
   input wire sdcfg_cfg_s               CFG_O
);
   // Spacing checks assume reset counts, so they stop once timing is reprogrammed.
   logic tw;
   wire  go = CMD_VALID_I && CMD_READY_O && CE_I;

   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I)
         tw <= 1'b0;
      else if (WR_STB_I && ADDR_I inside {8'h0c, 8'h10, 8'h14})
         tw <= 1'b1;
   end

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);

   a_ready_needs_valid: assert property (CMD_READY_O |-> CMD_VALID_I)
      else $error("ready without request");
   a_rdata_idle_zero: assert property ($past(CE_I) && !$past(RD_STB_I) |-> RD_DATA_O == '0)
      else $error("read data outside answer cycle");
   a_cfg_reset_value: assert property ($rose(RESETN_I) |-> CFG_O == '0 ##1
      (CFG_O.row_bits == 4'hc && CFG_O.cas_code == 3'h2 && CFG_O.off_chip_driver == 3'h7))
      else $error("configuration reset value wrong");
   a_row_bits_range: assert property ($past(RESETN_I) |-> CFG_O.row_bits inside {[4'hb:4'he]})
      else $error("row bits out of range");
   a_rcd_blocks_read: assert property (go && CMD_I == SDCFG_CMD_ACT && !tw ##1
      (CMD_I == SDCFG_CMD_READ && CMD_BANK_I == $past(CMD_BANK_I)) |-> !CMD_READY_O)
      else $error("read too soon after activate");
   a_rrd_blocks_act: assert property (go && CMD_I == SDCFG_CMD_ACT && !tw ##1
      (CMD_I == SDCFG_CMD_ACT && CMD_BANK_I != $past(CMD_BANK_I)) |-> !CMD_READY_O)
      else $error("activates too close");
   a_rp_blocks_all: assert property (go && CMD_I == SDCFG_CMD_PRE && !tw |=> !CMD_READY_O)
      else $error("command too soon after precharge");
   a_rfc_blocks_act: assert property (go && CMD_I == SDCFG_CMD_REFRESH && !tw |=>
      (CMD_I inside {SDCFG_CMD_ACT, SDCFG_CMD_REFRESH} |-> !CMD_READY_O))
      else $error("command too soon after refresh");

   c_act: cover property (go && CMD_I == SDCFG_CMD_ACT);
   c_pre: cover property (go && CMD_I == SDCFG_CMD_PRE);
   c_ref: cover property (go && CMD_I == SDCFG_CMD_REFRESH);
endmodule // sdcfg_timing_monitor

`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb;
   import sdcfg_pkg::*;
   localparam int NBANK = 4;
   logic        CLOCK_I = 1'b0, RESETN_I = 1'b0, CE_I = 1'b1, WR_STB_I = 1'b0;
   logic        RD_STB_I = 1'b0, CMD_VALID_I = 1'b0, sr_req = 1'b0, pd_req = 1'b0;
   logic        CMD_READY_O, EXIT_SELFREF_I, EXIT_PWRDN_I, PWRDN_ACTIVE_I;
   logic [7:0]  ADDR_I = 8'h00;
   logic [31:0] WR_DATA_I = 32'h0000_0000, RD_DATA_O;
   logic [1:0]  CMD_BANK_I = 2'h0;
   logic [15:0] cmd_count;
   sdcfg_cmd_e  CMD_I = SDCFG_CMD_NOP;
   sdcfg_cfg_s  CFG_O;
   wire logic [5:0] cfg_flags = {CFG_O.cas_legal, CFG_O.dll_reset, CFG_O.delay_loop_off,
      CFG_O.driver_impedance_sel, CFG_O.mask_lines_shared, CFG_O.cross_bank_stop_block};
   int          err_total = 0, check_count = 0, ncall = 0;
   logic [7:0]  ra [7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'he4, 8'h04};
   logic [31:0] rv [7] = '{32'h0000_7024, 32'h2022_7225, 32'h03c8_0808, 32'h0000_2062,
                           32'h0001_0000, 32'h0000_0000, 32'h0000_0000};

   sdcfg_timing #(.NBANK(NBANK)) dut (.*);
   sdcfg_mem_model mem (.CLOCK_I, .RESETN_I, .sr_req_i(sr_req), .pd_req_i(pd_req),
      .issued_i(CMD_VALID_I && CMD_READY_O && CE_I), .exit_sr_o(EXIT_SELFREF_I),
      .exit_pd_o(EXIT_PWRDN_I), .pd_act_o(PWRDN_ACTIVE_I), .cmd_count_o(cmd_count));

   always #25 CLOCK_I = ~CLOCK_I;

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      CMD_VALID_I <= 1'b0;
      WR_STB_I    <= 1'b1;
      ADDR_I      <= a;
      WR_DATA_I   <= d;
      @(posedge CLOCK_I);
      WR_STB_I    <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      CMD_VALID_I <= 1'b0;
      RD_STB_I    <= 1'b1;
      ADDR_I      <= a;
      @(posedge CLOCK_I);
      RD_STB_I    <= 1'b0;
      #1;
      `CHK("rdata", e, RD_DATA_O)
   endtask

   // The far side raises clock enable one edge after the request.
   task automatic wake(input logic pd);
      CMD_VALID_I <= 1'b0;
      sr_req      <= !pd;
      pd_req      <= pd;
      @(posedge CLOCK_I);
      sr_req      <= 1'b0;
      pd_req      <= 1'b0;
      @(posedge CLOCK_I);
      #1;
   endtask

   // Holds the request until ready, and expects e cycles of waiting.
   task automatic cmd(input sdcfg_cmd_e c, input logic [1:0] b, input int e);
      int n;
      n = 0;
      CMD_VALID_I <= 1'b1;
      CMD_I       <= c;
      CMD_BANK_I  <= b;
      #1;
      while (CMD_READY_O !== 1'b1 && n < 300) begin
         @(posedge CLOCK_I);
         #1;
         n++;
      end
      ncall++;
      `CHK("wait", e, n)
      if (n >= 300) begin
         results();
      end else begin
         @(posedge CLOCK_I);
         #1;
      end
   endtask

   initial begin
      repeat (2) @(posedge CLOCK_I);
      RESETN_I <= 1'b1;
      repeat (3) @(posedge CLOCK_I);
      #1;
      `CHK("row", 4'hc, CFG_O.row_bits)
      `CHK("cas", 3'h2, CFG_O.cas_code)
      `CHK("ocd", 3'h7, CFG_O.off_chip_driver)
      `CHK("flags", 6'h20, cfg_flags)
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      $display("done reset values");
      cmd(SDCFG_CMD_ACT, 2'h0, 0);
      cmd(SDCFG_CMD_REFRESH, 2'h0, 6);
      cmd(SDCFG_CMD_ACT, 2'h1, 7);
      cmd(SDCFG_CMD_ACT, 2'h2, 1);
      cmd(SDCFG_CMD_READ, 2'h2, 1);
      cmd(SDCFG_CMD_PRE, 2'h2, 2);
      cmd(SDCFG_CMD_NOP, 2'h0, 1);
      cmd(SDCFG_CMD_WRITE, 2'h1, 0);
      cmd(SDCFG_CMD_PRE, 2'h1, 1);
      cmd(SDCFG_CMD_LOAD_MODE, 2'h0, 1);
      cmd(SDCFG_CMD_ACT, 2'h3, 1);
      cmd(SDCFG_CMD_READ, 2'h0, 0);
      cmd(SDCFG_CMD_PRE, 2'h0, 1);
      $display("done reset spacing");
      wake(1'b0);
      cmd(SDCFG_CMD_READ, 2'h0, 0);
      cmd(SDCFG_CMD_ACT, 2'h1, 6);
      $display("done self refresh exit");
      wr(8'h0c, 32'h2022_7255);
      rd(8'h0c, 32'h2022_7255);
      cmd(SDCFG_CMD_ACT, 2'h0, 0);
      cmd(SDCFG_CMD_READ, 2'h0, 4);
      $display("done programmed spacing");
      wr(8'he4, 32'h0000_0001);
      wr(8'h0c, 32'h0000_0000);
      rd(8'h0c, 32'h2022_7255);
      wr(8'h08, 32'h0000_0000);
      rd(8'h08, 32'h0000_7024);
      wr(8'he4, 32'h0000_0000);
      wr(8'h08, 32'h0000_703c);
      wr(8'h08, 32'h0005_03bc);
      rd(8'h08, 32'h0005_03bc);
      `CHK("flags", 6'h3f, cfg_flags)
      `CHK("row", 4'he, CFG_O.row_bits)
      `CHK("cas", 3'h3, CFG_O.cas_code)
      `CHK("ocd", 3'h0, CFG_O.off_chip_driver)
      $display("done protection");
      wr(8'h20, 32'h0000_0006);
      wake(1'b1);
      cmd(SDCFG_CMD_NOP, 2'h0, 2);
      wake(1'b1);
      cmd(SDCFG_CMD_READ, 2'h0, 5);
      wr(8'h1c, 32'h0000_0000);
      wake(1'b1);
      cmd(SDCFG_CMD_READ, 2'h0, 2);
      `CHK("issued", ncall, cmd_count)
      $display("done power-down exit");
      results();
   end
endmodule // tb

bind sdcfg_timing sdcfg_timing_monitor #(.NBANK(NBANK)) mon (.*);

`default_nettype wire
